/* File: dv/tb_touch_scan_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_touch_scan_sequencer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, touchSense = 1'b0, slow = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, adcStart, settleActive, watchActive, pullupHigh, touch_irq_n;
  logic adcDone;
  logic [1:0] adcKind;
  logic [11:0] adcData, lastData;
  logic [1:0] kinds[$];
  int num_errors = 0, compares = 0;
  always #5 clk = ~clk;
  tss_touch_scan_sequencer dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .touchSense(touchSense), .adcDone(adcDone), .adcData(adcData),
    .adcStart(adcStart), .adcKind(adcKind), .settleActive(settleActive),
    .watchActive(watchActive), .pullupHigh(pullupHigh), .touch_irq_n(touch_irq_n));
  tss_adc_model adc (.clk(clk), .rst_n(rst_n), .adcStart(adcStart), .slow(slow),
    .adcDone(adcDone), .adcData(adcData), .lastData(lastData));
  always @(posedge clk) if (adcStart === 1'b1) kinds.push_back(adcKind);
  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check(32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, rv, e);
  endtask
  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0, rv, e);
  endtask
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 600; i++) begin
      rd(tss_pkg::REG_STATUS);
      if (rv[2:0] === s) break;
    end
    check(rv[2:0], s);
  endtask
  task automatic t_reset();
    logic e;
    check(touch_irq_n, 1'b1);
    rd(tss_pkg::REG_CTRL);
    check(rv, 32'h0);
    check(watchActive, 1'b1);
    apb(1'b0, 8'h40, 32'h0, rv, e);
    check(rv, 32'h0);
    check(e, 1'b1);
    wr(tss_pkg::REG_CTRL, 32'h8);
    repeat (2) @(posedge clk);
    check(pullupHigh, 1'b1);
    wr(tss_pkg::REG_CTRL, 32'h0);
  endtask
  task automatic t_single();
    touchSense <= 1'b1;
    repeat (10) @(posedge clk);
    kinds.delete();
    wr(tss_pkg::REG_CMD, 32'h22);
    wait_state(3'h0);
    check(kinds.size(), 1);
    check(kinds[0], 2'h1);
    rd(tss_pkg::REG_RESULT);
    check(rv[15:0], {2'h1, 2'h1, lastData});
    wr(tss_pkg::REG_CMD, 32'h20);
    wait_state(3'h0);
    rd(tss_pkg::REG_RESULT);
    check(rv[15:0], {2'h2, 2'h0, lastData});
  endtask
  task automatic t_chain();
    for (int s = 0; s < 3; s++) begin
      kinds.delete();
      wr(tss_pkg::REG_CMD, 32'h30 | (s << 1));
      wait_state(3'h0);
      check(kinds.size(), s + 2);
      foreach (kinds[i]) check(kinds[i], i);
    end
  endtask
  task automatic t_filter();
    wr(tss_pkg::REG_CTRL, 32'h4);
    kinds.delete();
    wr(tss_pkg::REG_CMD, 32'h20);
    wait_state(3'h0);
    check(kinds.size(), 4);
    rd(tss_pkg::REG_RESULT);
    check(rv[11:0], 12'h190);
    slow <= 1'b1;
    wr(tss_pkg::REG_CTRL, 32'h6);
    wr(tss_pkg::REG_CMD, 32'h22);
    wait_state(3'h0);
    rd(tss_pkg::REG_RESULT);
    check(rv[11:0], 12'h0FA);
    slow <= 1'b0;
  endtask
  task automatic t_stay();
    wr(tss_pkg::REG_CTRL, 32'h40);
    wr(tss_pkg::REG_CMD, 32'h10);
    repeat (450) @(posedge clk);
    rd(tss_pkg::REG_STATUS);
    check(rv[2:0], 3'h1);
    repeat (60) @(posedge clk);
    rd(tss_pkg::REG_STATUS);
    check(rv[2:0], 3'h2);
    wr(tss_pkg::REG_CMD, 32'h20);
    wait_state(3'h0);
    wr(tss_pkg::REG_CTRL, 32'h20);
    wr(tss_pkg::REG_CMD, 32'h12);
    repeat (300) @(posedge clk);
    check(settleActive, 1'b1);
    wr(tss_pkg::REG_STEP, 32'h1);
    wait_state(3'h2);
    wr(tss_pkg::REG_CTRL, 32'h0);
    wr(tss_pkg::REG_CMD, 32'h21);
    wait_state(3'h2);
    check(settleActive, 1'b1);
    wr(tss_pkg::REG_CMD, 32'h20);
    wait_state(3'h0);
  endtask
  task automatic t_irq();
    touchSense <= 1'b0;
    repeat (10) @(posedge clk);
    wr(tss_pkg::REG_IRQ_STAT, 32'h7);
    wr(tss_pkg::REG_IRQ_MASK, 32'h1);
    touchSense <= 1'b1;
    repeat (40) @(posedge clk);
    check(touch_irq_n, 1'b0);
    touchSense <= 1'b0;
    repeat (10) @(posedge clk);
    check(touch_irq_n, 1'b1);
    wr(tss_pkg::REG_CTRL, 32'h10);
    wr(tss_pkg::REG_IRQ_MASK, 32'h2);
    touchSense <= 1'b1;
    repeat (10) @(posedge clk);
    check(touch_irq_n, 1'b0);
    wr(tss_pkg::REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk);
    check(touch_irq_n, 1'b1);
    touchSense <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic t_selfrun();
    int n;
    wr(tss_pkg::REG_IRQ_MASK, 32'h4);
    wr(tss_pkg::REG_IRQ_STAT, 32'h7);
    wr(tss_pkg::REG_CTRL, 32'h1);
    kinds.delete();
    touchSense <= 1'b1;
    for (n = 0; n < 3000 && kinds.size() < 2; n++) @(posedge clk);
    touchSense <= 1'b0;
    wait_state(3'h0);
    check(touch_irq_n, 1'b0);
    rd(tss_pkg::REG_STATUS);
    n = rv[14:8];
    check(n, kinds.size());
    rd(tss_pkg::REG_FIFO);
    check(rv[13:12], 2'h0);
    repeat (2) @(posedge clk);
    check(touch_irq_n, 1'b1);
    rd(tss_pkg::REG_STATUS);
    check(rv[14:8], n - 1);
    rd(tss_pkg::REG_FIFO);
    check(rv[13:12], 2'h1);
  endtask
  initial begin
    #900000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_single();
    t_chain();
    t_filter();
    t_stay();
    t_irq();
    t_selfrun();
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: dv/tss_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tss_adc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adcStart,
  input wire logic slow,
  output logic adcDone,
  output logic [tss_pkg::DATA_W-1:0] adcData,
  output logic [tss_pkg::DATA_W-1:0] lastData
);
  logic busy_ff;
  logic [7:0] wait_ff;
  logic [1:0] idx_ff;
  // any four consecutive draws are a permutation of this table, so set means are fixed
  function automatic logic [tss_pkg::DATA_W-1:0] sample(input logic [1:0] i);
    case (i)
      2'h0: return 12'h064;
      2'h1: return 12'h0C8;
      2'h2: return 12'h12C;
      default: return 12'h3E8;
    endcase
  endfunction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      wait_ff <= 8'h00;
      idx_ff <= 2'h0;
      adcDone <= 1'b0;
      adcData <= 12'hA5A;
      lastData <= 12'h000;
    end else begin
      adcDone <= 1'b0;
      // stale data toggles so a late sample never looks like a fresh result
      adcData <= ~adcData;
      if (adcStart && !busy_ff) begin
        busy_ff <= 1'b1;
        wait_ff <= slow ? 8'h28 : 8'h02;
      end else if (busy_ff && wait_ff != 8'h00) begin
        wait_ff <= wait_ff - 8'h01;
      end else if (busy_ff) begin
        busy_ff <= 1'b0;
        adcDone <= 1'b1;
        adcData <= sample(idx_ff);
        lastData <= sample(idx_ff);
        idx_ff <= idx_ff + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/tss_pkg.sv */
`default_nettype none
package tss_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_FIFO = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_STEP = 8'h1C;
  localparam int CTRL_SELF_RUN = 0;
  localparam int CTRL_MEDIAN = 1;
  localparam int CTRL_AVG = 2;
  localparam int CTRL_PULLUP = 3;
  localparam int CTRL_ONSET = 4;
  localparam int CTRL_UNTIMED = 5;
  localparam int CTRL_DLY = 6;
  localparam int CTRL_SET = 8;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam int CMD_STAY = 0;
  localparam int CMD_KIND = 1;
  localparam int CMD_OP = 4;
  localparam logic [1:0] OP_SETTLE = 2'h1;
  localparam logic [1:0] OP_MEASURE = 2'h2;
  localparam logic [1:0] OP_CHAIN = 2'h3;
  localparam logic [1:0] CHAIN_XY = 2'h0;
  localparam logic [1:0] CHAIN_XYZ1 = 2'h1;
  localparam int IRQ_LEVEL = 0;
  localparam int IRQ_ONSET = 1;
  localparam int IRQ_FIFO = 2;
  localparam int IRQ_W = 3;
  localparam int STAT_TOUCH = 3;
  localparam int STAT_LEVEL = 8;
  localparam int DATA_W = 12;
  localparam int WORD_W = 16;
  localparam int FIFO_BITS = 1024;
  localparam int FIFO_DEPTH = FIFO_BITS / WORD_W;
  localparam int AVG_LOG2 = 2;
  localparam int AVG_N = 1 << AVG_LOG2;
  localparam int TIMER_W = 16;
  localparam int SETTLE_US0 = 1;
  localparam int SETTLE_US1 = 5;
  localparam int SETTLE_US2 = 10;
  localparam int SETTLE_US3 = 20;
  localparam int SETTLE_CYC0 = SETTLE_US0 * CLK_MHZ;
  localparam int SETTLE_CYC1 = SETTLE_US1 * CLK_MHZ;
  localparam int SETTLE_CYC2 = SETTLE_US2 * CLK_MHZ;
  localparam int SETTLE_CYC3 = SETTLE_US3 * CLK_MHZ;
  typedef enum logic [1:0] {KIND_X, KIND_Y, KIND_Z1, KIND_Z2} tss_kind_e;
  typedef enum logic [1:0] {TOUCH_NONE, TOUCH_INITIAL, TOUCH_STAY_IN_SETTLE, TOUCH_RELEASE} tss_touch_e;
  typedef enum logic [2:0] {ST_WATCH, ST_SETTLE, ST_HOLD, ST_CONV, ST_WAIT, ST_STORE} tss_state_e;
  typedef struct packed {
    tss_touch_e touchTag;
    tss_kind_e kindTag;
    logic [DATA_W-1:0] data;
  } tss_result_s;
endpackage
`default_nettype wire

/* File: verilog/tss_touch_scan_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module tss_touch_scan_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [tss_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic touchSense,
  input wire logic adcDone,
  input wire logic [tss_pkg::DATA_W-1:0] adcData,
  output logic adcStart,
  output logic [1:0] adcKind,
  output logic settleActive,
  output logic watchActive,
  output logic pullupHigh,
  output logic touch_irq_n
);
  localparam int LVL_W = $clog2(tss_pkg::FIFO_DEPTH) + 1;
  localparam int PTR_W = $clog2(tss_pkg::FIFO_DEPTH);
  localparam int SUM_W = tss_pkg::DATA_W + tss_pkg::AVG_LOG2;
  localparam int CNT_W = tss_pkg::AVG_LOG2 + 1;

  logic [2:0] touchSync_ff;
  logic touched_ff, touchPrev_ff, wasTouched_ff;
  logic pready_ff, pslverr_ff, fifoArmed_ff;
  logic [31:0] prdata_ff, readMux;
  logic [tss_pkg::CTRL_W-1:0] ctrl_ff;
  logic [tss_pkg::IRQ_W-1:0] irqStat_ff, irqMask_ff, evt, clr;
  tss_pkg::tss_state_e state_ff;
  tss_pkg::tss_kind_e kind_ff, lastKind_ff;
  logic stay_ff, measPend_ff;
  logic [tss_pkg::TIMER_W-1:0] timer_ff;
  logic [SUM_W-1:0] sum_ff, trimmed;
  logic [tss_pkg::DATA_W-1:0] min_ff, max_ff, filtered;
  logic [CNT_W-1:0] sampCnt_ff;
  tss_pkg::tss_result_s result_ff, nxt_result;
  tss_pkg::tss_touch_e touchTag;
  tss_pkg::tss_result_s fifoMem [tss_pkg::FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_ff, rdPtr_ff;
  logic [LVL_W-1:0] level_ff;
  logic adcStart_ff, settleActive_ff, watchActive_ff, pullupHigh_ff, irqN_ff;

  logic setup, access, wr, rd, selfRun, untimed, avgOn, cmdWr, stepWr, cmdAccept;
  logic startSelf, settleDone, lastSample, push, pop;
  logic [1:0] cmdOp, cmdKind;

  function automatic logic mapped(input logic [tss_pkg::ADDR_W-1:0] a);
    mapped = (a == tss_pkg::REG_CTRL) || (a == tss_pkg::REG_CMD) ||
             (a == tss_pkg::REG_STATUS) || (a == tss_pkg::REG_RESULT) ||
             (a == tss_pkg::REG_FIFO) || (a == tss_pkg::REG_IRQ_STAT) ||
             (a == tss_pkg::REG_IRQ_MASK) || (a == tss_pkg::REG_STEP);
  endfunction

  function automatic logic [tss_pkg::TIMER_W-1:0] settleLoad(input logic [1:0] sel);
    case (sel)
      2'h0: settleLoad = tss_pkg::TIMER_W'(tss_pkg::SETTLE_CYC0 - 1);
      2'h1: settleLoad = tss_pkg::TIMER_W'(tss_pkg::SETTLE_CYC1 - 1);
      2'h2: settleLoad = tss_pkg::TIMER_W'(tss_pkg::SETTLE_CYC2 - 1);
      default: settleLoad = tss_pkg::TIMER_W'(tss_pkg::SETTLE_CYC3 - 1);
    endcase
  endfunction

  function automatic tss_pkg::tss_kind_e chainEnd(input logic [1:0] set);
    case (set)
      tss_pkg::CHAIN_XY: chainEnd = tss_pkg::KIND_Y;
      tss_pkg::CHAIN_XYZ1: chainEnd = tss_pkg::KIND_Z1;
      default: chainEnd = tss_pkg::KIND_Z2;
    endcase
  endfunction

  // touch pin: a change counts once the second and third stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touchSync_ff <= 3'h0;
      touched_ff <= 1'b0;
      touchPrev_ff <= 1'b0;
    end else begin
      touchSync_ff <= {touchSync_ff[1:0], touchSense};
      if (touchSync_ff[1] == touchSync_ff[2]) touched_ff <= touchSync_ff[2];
      touchPrev_ff <= touched_ff;
    end
  end

  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign selfRun = ctrl_ff[tss_pkg::CTRL_SELF_RUN];
  // host pacing is refused in self-run so a scan there can never hang
  assign untimed = ctrl_ff[tss_pkg::CTRL_UNTIMED] & ~selfRun;
  assign avgOn = ctrl_ff[tss_pkg::CTRL_AVG];
  assign cmdWr = wr & (paddr == tss_pkg::REG_CMD);
  assign stepWr = wr & (paddr == tss_pkg::REG_STEP) & pwdata[0];
  assign cmdOp = pwdata[tss_pkg::CMD_OP +: 2];
  assign cmdKind = pwdata[tss_pkg::CMD_KIND +: 2];
  assign cmdAccept = cmdWr & ~selfRun & (cmdOp != 2'h0) & ((state_ff == tss_pkg::ST_WATCH) ||
    (state_ff == tss_pkg::ST_HOLD) || ((state_ff == tss_pkg::ST_SETTLE) && untimed));
  assign startSelf = selfRun & (state_ff == tss_pkg::ST_WATCH) & touched_ff;
  assign settleDone = untimed ? stepWr : (timer_ff == '0);
  assign lastSample = avgOn ? (sampCnt_ff == CNT_W'(tss_pkg::AVG_N - 1)) : 1'b1;
  assign push = (state_ff == tss_pkg::ST_STORE) & selfRun &
                (level_ff != LVL_W'(tss_pkg::FIFO_DEPTH));
  assign pop = rd & (paddr == tss_pkg::REG_FIFO) & fifoArmed_ff;

  always_comb begin
    readMux = '0;
    case (paddr)
      tss_pkg::REG_CTRL: readMux[tss_pkg::CTRL_W-1:0] = ctrl_ff;
      tss_pkg::REG_STATUS: begin
        readMux[2:0] = state_ff;
        readMux[tss_pkg::STAT_TOUCH] = touched_ff;
        readMux[tss_pkg::STAT_LEVEL +: LVL_W] = level_ff;
      end
      tss_pkg::REG_RESULT: readMux[tss_pkg::WORD_W-1:0] = result_ff;
      tss_pkg::REG_FIFO: readMux[tss_pkg::WORD_W-1:0] = (level_ff != '0) ? fifoMem[rdPtr_ff] : '0;
      tss_pkg::REG_IRQ_STAT: readMux[tss_pkg::IRQ_W-1:0] = irqStat_ff;
      tss_pkg::REG_IRQ_MASK: readMux[tss_pkg::IRQ_W-1:0] = irqMask_ff;
      default: readMux = '0;
    endcase
  end

  // no wait states: read data is captured at setup so the fifo pop and its data agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      fifoArmed_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      // pop only a word captured at setup; one pushed mid-transfer stays queued
      fifoArmed_ff <= setup & (level_ff != '0);
      pslverr_ff <= setup & ~mapped(paddr);
      if (setup) prdata_ff <= pwrite ? '0 : readMux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= tss_pkg::CTRL_RESET;
      irqMask_ff <= '0;
    end else begin
      if (wr && paddr == tss_pkg::REG_CTRL) ctrl_ff <= pwdata[tss_pkg::CTRL_W-1:0];
      if (wr && paddr == tss_pkg::REG_IRQ_MASK) irqMask_ff <= pwdata[tss_pkg::IRQ_W-1:0];
    end
  end

  always_comb begin
    evt = '0;
    evt[tss_pkg::IRQ_LEVEL] = ~selfRun & ~ctrl_ff[tss_pkg::CTRL_ONSET] & touched_ff;
    evt[tss_pkg::IRQ_ONSET] = ~selfRun & ctrl_ff[tss_pkg::CTRL_ONSET] &
                              touched_ff & ~touchPrev_ff;
    evt[tss_pkg::IRQ_FIFO] = push;
    clr = (wr && paddr == tss_pkg::REG_IRQ_STAT) ? pwdata[tss_pkg::IRQ_W-1:0] : '0;
    clr[tss_pkg::IRQ_LEVEL] = clr[tss_pkg::IRQ_LEVEL] | ~touched_ff;
    clr[tss_pkg::IRQ_FIFO] = clr[tss_pkg::IRQ_FIFO] | pop;
  end

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_ff <= '0;
      irqN_ff <= 1'b1;
    end else begin
      irqStat_ff <= (irqStat_ff & ~clr) | evt;
      irqN_ff <= ~|(irqStat_ff & irqMask_ff);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= tss_pkg::ST_WATCH;
      kind_ff <= tss_pkg::KIND_X;
      lastKind_ff <= tss_pkg::KIND_X;
      stay_ff <= 1'b0;
      measPend_ff <= 1'b0;
      timer_ff <= '0;
    end else begin
      case (state_ff)
        tss_pkg::ST_WATCH, tss_pkg::ST_HOLD, tss_pkg::ST_SETTLE: begin
          if (cmdAccept) begin
            stay_ff <= pwdata[tss_pkg::CMD_STAY];
            timer_ff <= settleLoad(ctrl_ff[tss_pkg::CTRL_DLY +: 2]);
            measPend_ff <= (cmdOp != tss_pkg::OP_SETTLE);
            if (cmdOp == tss_pkg::OP_CHAIN) begin
              kind_ff <= tss_pkg::KIND_X;
              lastKind_ff <= chainEnd(cmdKind);
              state_ff <= tss_pkg::ST_SETTLE;
            end else begin
              kind_ff <= tss_pkg::tss_kind_e'(cmdKind);
              lastKind_ff <= tss_pkg::tss_kind_e'(cmdKind);
              // panel already set up: a measure from a settle wait converts at once
              if (cmdOp == tss_pkg::OP_MEASURE && state_ff != tss_pkg::ST_WATCH) begin
                state_ff <= tss_pkg::ST_CONV;
              end else begin
                state_ff <= tss_pkg::ST_SETTLE;
              end
            end
          end else if (startSelf) begin
            kind_ff <= tss_pkg::KIND_X;
            lastKind_ff <= chainEnd(ctrl_ff[tss_pkg::CTRL_SET +: 2]);
            stay_ff <= 1'b0;
            measPend_ff <= 1'b1;
            timer_ff <= settleLoad(ctrl_ff[tss_pkg::CTRL_DLY +: 2]);
            state_ff <= tss_pkg::ST_SETTLE;
          end else if (state_ff == tss_pkg::ST_SETTLE) begin
            if (timer_ff != '0) timer_ff <= timer_ff - 1'b1;
            if (settleDone) state_ff <= measPend_ff ? tss_pkg::ST_CONV : tss_pkg::ST_HOLD;
          end
        end
        tss_pkg::ST_CONV: state_ff <= tss_pkg::ST_WAIT;
        tss_pkg::ST_WAIT: begin
          if (adcDone) state_ff <= lastSample ? tss_pkg::ST_STORE : tss_pkg::ST_CONV;
        end
        tss_pkg::ST_STORE: begin
          if (kind_ff != lastKind_ff) begin
            kind_ff <= tss_pkg::tss_kind_e'(kind_ff + 2'h1);
            timer_ff <= settleLoad(ctrl_ff[tss_pkg::CTRL_DLY +: 2]);
            state_ff <= untimed ? tss_pkg::ST_CONV : tss_pkg::ST_SETTLE;
          end else begin
            state_ff <= stay_ff ? tss_pkg::ST_HOLD : tss_pkg::ST_WATCH;
          end
        end
        default: state_ff <= tss_pkg::ST_WATCH;
      endcase
    end
  end

  // sample set collection; the set restarts whenever no conversion is running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_ff <= '0;
      min_ff <= '1;
      max_ff <= '0;
      sampCnt_ff <= '0;
    end else if (state_ff == tss_pkg::ST_WAIT && adcDone) begin
      sum_ff <= sum_ff + SUM_W'(adcData);
      if (adcData < min_ff) min_ff <= adcData;
      if (adcData > max_ff) max_ff <= adcData;
      sampCnt_ff <= sampCnt_ff + 1'b1;
    end else if (state_ff != tss_pkg::ST_CONV && state_ff != tss_pkg::ST_WAIT) begin
      sum_ff <= '0;
      min_ff <= '1;
      max_ff <= '0;
      sampCnt_ff <= '0;
    end
  end

  assign trimmed = sum_ff - SUM_W'(min_ff) - SUM_W'(max_ff);
  assign nxt_result = '{touchTag: touchTag, kindTag: kind_ff, data: filtered};
  always_comb begin
    if (!avgOn) begin
      filtered = sum_ff[tss_pkg::DATA_W-1:0];
    end else if (ctrl_ff[tss_pkg::CTRL_MEDIAN]) begin
      // two samples remain after trimming, so halving gives their mean
      filtered = trimmed[tss_pkg::AVG_LOG2-1 +: tss_pkg::DATA_W];
    end else begin
      filtered = sum_ff[tss_pkg::AVG_LOG2 +: tss_pkg::DATA_W];
    end
    case ({wasTouched_ff, touched_ff})
      2'b01: touchTag = tss_pkg::TOUCH_INITIAL;
      2'b11: touchTag = tss_pkg::TOUCH_STAY_IN_SETTLE;
      2'b10: touchTag = tss_pkg::TOUCH_RELEASE;
      default: touchTag = tss_pkg::TOUCH_NONE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= '0;
      wasTouched_ff <= 1'b0;
    end else if (state_ff == tss_pkg::ST_STORE) begin
      result_ff <= nxt_result;
      wasTouched_ff <= touched_ff;
    end
  end

  // full fifo drops the new word rather than overwrite unread data
  always_ff @(posedge clk) begin
    // result_ff only updates at this same edge, so the fresh word is written
    if (push) fifoMem[wrPtr_ff] <= nxt_result;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      level_ff <= '0;
    end else begin
      if (push) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (pop) rdPtr_ff <= rdPtr_ff + 1'b1;
      level_ff <= level_ff + LVL_W'(push) - LVL_W'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adcStart_ff <= 1'b0;
      settleActive_ff <= 1'b0;
      watchActive_ff <= 1'b0;
      pullupHigh_ff <= 1'b0;
    end else begin
      adcStart_ff <= (state_ff == tss_pkg::ST_CONV);
      settleActive_ff <= (state_ff == tss_pkg::ST_SETTLE) || (state_ff == tss_pkg::ST_HOLD);
      watchActive_ff <= (state_ff == tss_pkg::ST_WATCH);
      pullupHigh_ff <= ctrl_ff[tss_pkg::CTRL_PULLUP];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign adcStart = adcStart_ff;
  assign adcKind = kind_ff;
  assign settleActive = settleActive_ff;
  assign watchActive = watchActive_ff;
  assign pullupHigh = pullupHigh_ff;
  assign touch_irq_n = irqN_ff;

  property p_trim_mean;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == tss_pkg::ST_STORE) && avgOn && ctrl_ff[tss_pkg::CTRL_MEDIAN]
      |=> result_ff.data == $past(trimmed[tss_pkg::AVG_LOG2-1 +: tss_pkg::DATA_W]);
  endproperty
  a_trim_mean: assert property (p_trim_mean) else $error("trimmed mean wrong");
  property p_avg_count;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == tss_pkg::ST_STORE) && avgOn |-> sampCnt_ff == CNT_W'(tss_pkg::AVG_N);
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("sample set size wrong");
  property p_self_start;
    @(posedge clk) disable iff (!rst_n)
    startSelf |=> (state_ff == tss_pkg::ST_SETTLE) && (kind_ff == tss_pkg::KIND_X);
  endproperty
  a_self_start: assert property (p_self_start) else $error("self-run did not start");
  property p_settle_hold;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == tss_pkg::ST_SETTLE) && !untimed && (timer_ff != '0) && !cmdAccept
      |=> (state_ff == tss_pkg::ST_SETTLE) && (timer_ff == $past(timer_ff) - 1'b1);
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("settle ended early");
  property p_chain_next;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == tss_pkg::ST_STORE) && (kind_ff != lastKind_ff)
      |=> kind_ff == tss_pkg::tss_kind_e'($past(kind_ff) + 2'h1);
  endproperty
  a_chain_next: assert property (p_chain_next) else $error("chain did not advance");
  property p_stay;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == tss_pkg::ST_STORE) && (kind_ff == lastKind_ff)
      |=> state_ff == ($past(stay_ff) ? tss_pkg::ST_HOLD : tss_pkg::ST_WATCH);
  endproperty
  a_stay: assert property (p_stay) else $error("wrong state after conversion");
  property p_tag;
    @(posedge clk) disable iff (!rst_n)
    state_ff == tss_pkg::ST_STORE |=> result_ff.kindTag == $past(kind_ff);
  endproperty
  a_tag: assert property (p_tag) else $error("kind tag wrong");
  property p_irq_out;
    @(posedge clk) disable iff (!rst_n)
    |(irqStat_ff & irqMask_ff) |=> !touch_irq_n;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt not driven low");
  property p_level_irq;
    @(posedge clk) disable iff (!rst_n)
    !touched_ff |=> !irqStat_ff[tss_pkg::IRQ_LEVEL];
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level irq outlived touch");
  property p_read_clear;
    @(posedge clk) disable iff (!rst_n)
    pop && !push |=> !irqStat_ff[tss_pkg::IRQ_FIFO] && (level_ff == $past(level_ff) - 1'b1);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("fifo read did not clear");
endmodule
`default_nettype wire
